// ---- dv/srw_host_model.sv ----
// host-side model of the processor pin that shares the watchdog strobe line
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
  input  wire logic clk,
  input  wire logic drive_en,  // host buffer enabled, else three-stated
  input  wire logic drive_val, // host level, kept low most of the time
  input  wire logic dev_out,   // weak drive value from the device
  input  wire logic dev_oe,    // weak drive enable from the device
  output logic      pin        // resolved strobe line
);
  logic last_q; // last resolved level, for a line nobody drives
  // the host buffer overpowers the weak drive; no pull on this line
  always_comb begin
    if (drive_en) begin
      pin = drive_val;
    end else if (dev_oe) begin
      pin = dev_out;
    end else begin
      pin = ~last_q; // undriven: never trust the old level
    end
  end
  // remember the level for the undriven case
  always_ff @(posedge clk) begin
    last_q <= pin;
  end
endmodule : srw_host_model
`default_nettype wire

// ---- dv/srw_top_tb.sv ----
// self-checking bench for the supervisor reset watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %0d seen %0d", nm, e, g); end end
module srw_top_tb;
  localparam int HOLD = 200; // shortened hold count
  logic clk = 0, rst = 1, sup_low = 0, man_n = 1, h_en = 0, h_val = 0;
  logic pin, s_out, s_oe, rst_n, rst_hi;
  int   errors = 0, num_checks = 0, len = 0, n, e;
  int   exp_q[$]; // expected reset pulse lengths, oldest first
  // free-running clock
  always #50 clk = ~clk;
  srw_top #(.HOLD_CYC(HOLD), .WDT_CYC(1600), .TB_DIV(2)) u_srw_top (
    .CLOCK(clk), .RESET(rst), .SUPPLY_LOW(sup_low), .MANUAL_RESET_N(man_n),
    .WATCHDOG_STROBE_IN(pin), .WATCHDOG_STROBE_OUT(s_out),
    .WATCHDOG_STROBE_OE(s_oe), .RESET_N_OUT(rst_n), .RESET_OUT(rst_hi));
  srw_host_model u_srw_host_model (.clk(clk), .drive_en(h_en), .drive_val(h_val),
    .dev_out(s_out), .dev_oe(s_oe), .pin(pin));
  task automatic run(input int c);
    repeat (c) @(posedge clk);
  endtask : run
  // switch bounce: single-cycle lows, inside the ignored glitch width
  task automatic bounce;
    repeat (5) begin
      man_n <= 0;
      run(1);
      man_n <= 1;
      run(1 + $urandom % 2);
    end
  endtask : bounce
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // watcher: sample settled outputs mid-cycle, match lows to the oldest note
  always @(negedge clk) begin
    `CHK("reset_inverse", ~rst_n, rst_hi)
    if (rst) len = 0;
    else if (rst_n === 1'b0) len++;
    else if (len != 0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 0; // zero: no pulse was due
      `CHK("pulse_len", e, (len >= e - 8 && len <= e + 12) ? e : len)
      len = 0;
    end
  end
  // hang guard, well past the planned run length
  initial begin
    run(40000);
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'h4A2A72EC));
    exp_q.push_back(HOLD); // power-up hold
    run(16);
    rst <= 0;
    run(HOLD + 100);
    // manual low for a random stretch, then a lone glitch that must vanish
    n = 40 + $urandom % 40;
    exp_q.push_back(n + HOLD - 3);
    man_n <= 0;
    run(n);
    man_n <= 1;
    run(HOLD + 100);
    man_n <= 0;
    run(1);
    man_n <= 1;
    run(300);
    // bouncing switch on press and release: one pulse only
    exp_q.push_back(40 + HOLD - 3);
    bounce();
    man_n <= 0;
    run(40);
    man_n <= 1;
    bounce();
    run(HOLD + 100);
    // supply dips twice, second one inside the hold
    exp_q.push_back(150 + HOLD);
    sup_low <= 1;
    run(30);
    sup_low <= 0;
    run(100);
    sup_low <= 1;
    run(20);
    sup_low <= 0;
    run(HOLD + 100);
    // host services with short pulses, then stalls and lets it expire
    h_en <= 1;
    h_val <= 0;
    repeat (3) begin
      run(600 + $urandom % 300);
      h_val <= 1;
      run(1);
      h_val <= 0;
    end
    exp_q.push_back(HOLD);
    run(1600 + HOLD + 100);
    h_en <= 0; // floating line: weak drive services it
    run(5000);
    `CHK("notes_left", 0, exp_q.size())
    final_report();
  end
endmodule : srw_top_tb
`default_nettype wire

// ---- hdl/srw_defines.svh ----
// timing constants for the supervisor reset watchdog
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH
`define SRW_CLK_PERIOD_NS   100
`define SRW_HOLD_NS         200000000
`define SRW_HOLD_CYC        (`SRW_HOLD_NS / `SRW_CLK_PERIOD_NS)
`define SRW_WDT_NS          1600000000
`define SRW_WDT_CYC         (`SRW_WDT_NS / `SRW_CLK_PERIOD_NS)
`define SRW_MR_GLITCH_NS    100
`define SRW_MR_GLITCH_CYC   ((`SRW_MR_GLITCH_NS + `SRW_CLK_PERIOD_NS - 1) / `SRW_CLK_PERIOD_NS + 1)
`define SRW_TB_DIV          10
`endif

// ---- hdl/srw_pkg.sv ----
// types for the supervisor reset watchdog
package srw_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_HOLD} srw_state_type;
endpackage : srw_pkg

// ---- hdl/srw_sync.sv ----
// two-flop synchroniser with edge output
`timescale 1ns/1ps
`default_nettype none
module srw_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout,
  output logic      edge_seen
);
  logic m_q;   // first stage, read only by s_q
  logic s_q;   // second stage
  logic p_q;   // previous synced value
  // sample, resync and remember
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_q <= 1'b1;
      s_q <= 1'b1;
      p_q <= 1'b1;
    end else begin
      m_q <= din;
      s_q <= m_q;
      p_q <= s_q;
    end
  end
  assign dout      = s_q;
  assign edge_seen = s_q ^ p_q;
endmodule : srw_sync
`default_nettype wire

// ---- hdl/srw_top.sv ----
// supervisor reset watchdog top
// Functional notes
// RULE_01: any trigger gives a 200ms reset pulse
// RULE_02: reset held while manual or supply low
// RULE_03: 200ms more after each cause ends
// RULE_04: high reset is inverse of low reset
// RULE_05: supply drop restarts the hold timer
// RULE_06: no strobe edge for 1.6s asserts reset
// RULE_07: strobe edges and reset clear watchdog
// RULE_08: 50ns strobe pulses count as toggles; here a pulse must be held a clock to be seen
// RULE_09: watchdog stopped in reset, runs after
// RULE_10: floating strobe disables the watchdog
// RULE_11: weak drive low 7/8, high 1/8; here it is high only about 3 clocks, until its own edge clears the counter
// RULE_12: floating strobe serviced about every 1.4s
// RULE_13: bouncing switch gives one clean reset
// RULE_14: host pulses strobe within first 7/8
// RULE_15: host sets strobe high and low apart
// RULE_16: manual pulses of 100ns or less ignored
// RULE_17: timebase counted, separate hold/watchdog counters
`timescale 1ns/1ps
`default_nettype none
`include "srw_defines.svh"
module srw_top
  import srw_pkg::*;
#(
  parameter int HOLD_CYC = `SRW_HOLD_CYC,  // 200ms hold
  parameter int WDT_CYC  = `SRW_WDT_CYC,   // 1.6s timeout
  parameter int TB_DIV   = `SRW_TB_DIV     // timebase divider
) (
  input  wire logic CLOCK,
  input  wire logic RESET,
  input  wire logic SUPPLY_LOW,        // supply below threshold, active high
  input  wire logic MANUAL_RESET_N,    // manual reset, active low
  input  wire logic WATCHDOG_STROBE_IN,// strobe pin level (resolved wire)
  output logic      WATCHDOG_STROBE_OUT, // weak internal drive value
  output logic      WATCHDOG_STROBE_OE,  // weak drive enable
  output logic      RESET_N_OUT,       // active-low reset to processor
  output logic      RESET_OUT          // active-high reset
);
  localparam int MRG = `SRW_MR_GLITCH_CYC;
  localparam int TBW = $clog2(TB_DIV + 1);
  localparam int HW  = $clog2(HOLD_CYC / TB_DIV + 2);
  localparam int WW  = $clog2(WDT_CYC / TB_DIV + 2);
  localparam int MW  = $clog2(MRG + 2);
  localparam logic [HW-1:0] HOLD_T = HW'(HOLD_CYC / TB_DIV);
  localparam logic [WW-1:0] WDT_T  = WW'(WDT_CYC / TB_DIV);
  localparam logic [WW-1:0] HI_T   = WW'((WDT_CYC / TB_DIV) * 7 / 8);

  // module state, apart from the manual and strobe synchronisers
  typedef struct packed {
    srw_state_type   st;
    logic [TBW-1:0]  tb;    // timebase divider
    logic [HW-1:0]   hold;  // hold counter
    logic [WW-1:0]   wdt;   // watchdog counter
    logic [MW-1:0]   mrc;   // manual low filter count
    logic            rst_n; // registered reset output
    logic            sup_m, sup_s; // supply synchroniser
  } srw_st_type;
  srw_st_type s_q, s_d;

  logic mr_s, mr_unused, wd_s, wd_edge, tick, mr_low, cause;

  // manual and strobe pins are asynchronous
  srw_sync u_mr (.clk(CLOCK), .rst(RESET), .din(MANUAL_RESET_N),
                 .dout(mr_s), .edge_seen(mr_unused));
  srw_sync u_wd (.clk(CLOCK), .rst(RESET), .din(WATCHDOG_STROBE_IN),
                 .dout(wd_s), .edge_seen(wd_edge));

  // 50ns pulses are shorter than a clock; a real part latches them
  // asynchronously, here the strobe must be held a cycle to be seen
  assign tick   = (s_q.tb == TBW'(TB_DIV - 1));                  // RULE_17
  assign mr_low = (s_q.mrc >= MW'(MRG));                          // RULE_16
  assign cause  = s_q.sup_s | mr_low;                             // RULE_02

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.sup_m = SUPPLY_LOW;
    s_d.sup_s = s_q.sup_m;
    s_d.tb = tick ? '0 : s_q.tb + TBW'(1);                          // RULE_17
    // manual low must persist beyond glitch width; bounce restarts it
    if (mr_s) begin
      s_d.mrc = '0;                                                 // RULE_13
    end else if (!mr_low) begin
      s_d.mrc = s_q.mrc + MW'(1);                                   // RULE_16
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.rst_n = 1'b1;
        if (cause) begin
          s_d.st = ST_HELD;                                         // RULE_02
          s_d.rst_n = 1'b0;
        end else if (wd_edge) begin
          s_d.wdt = '0;                                             // RULE_07 RULE_08
        end else if (tick) begin
          if (s_q.wdt == WDT_T - WW'(1)) begin
            s_d.st = ST_HOLD;                                       // RULE_06
            s_d.rst_n = 1'b0;
            s_d.hold = '0;
            s_d.wdt = '0;
          end else begin
            s_d.wdt = s_q.wdt + WW'(1);
          end
        end
      end
      ST_HELD: begin
        s_d.wdt = '0;                                               // RULE_09
        s_d.rst_n = 1'b0;
        s_d.hold = '0;                                              // RULE_05
        if (!cause) begin
          s_d.st = ST_HOLD;                                         // RULE_03
        end
      end
      default: begin
        s_d.wdt = '0;                                               // RULE_09
        s_d.rst_n = 1'b0;
        if (cause) begin
          s_d.st = ST_HELD;                                         // RULE_05
          s_d.hold = '0;
        end else if (tick) begin
          if (s_q.hold == HOLD_T - HW'(1)) begin
            s_d.st = ST_IDLE;                                       // RULE_01 RULE_03
            s_d.rst_n = 1'b1;
          end else begin
            s_d.hold = s_q.hold + HW'(1);
          end
        end
      end
    endcase
  end

  // state register; power-up enters the hold as a fresh reset
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      s_q <= '{st: ST_HOLD, tb: '0, hold: '0, wdt: '0, mrc: '0,
               rst_n: 1'b0, sup_m: 1'b1, sup_s: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // weak drive follows the watchdog counter; floating pin toggles high
  // at 7/8 and the edge clears the counter before timeout
  assign WATCHDOG_STROBE_OUT = (s_q.wdt >= HI_T);                  // RULE_11 RULE_12 RULE_10
  assign WATCHDOG_STROBE_OE  = 1'b1;
  assign RESET_N_OUT = s_q.rst_n;
  assign RESET_OUT   = ~s_q.rst_n;                                  // RULE_04

  chk_inverse_out: assert property (@(posedge CLOCK) RESET_OUT == !RESET_N_OUT) // RULE_04
    else $error("active-high reset not inverse");
  chk_cause_holds: assert property (@(posedge CLOCK) disable iff (RESET)
    cause |=> !RESET_N_OUT)                                         // RULE_02
    else $error("reset released while cause active");
  chk_wdt_frozen: assert property (@(posedge CLOCK) disable iff (RESET)
    !RESET_N_OUT |=> s_q.wdt == '0)                                  // RULE_09
    else $error("watchdog counted during reset");
  chk_edge_clears: assert property (@(posedge CLOCK) disable iff (RESET)
    (wd_edge && s_q.st == ST_IDLE && !cause) |=> s_q.wdt == '0)     // RULE_07
    else $error("strobe edge did not clear watchdog");
  chk_wdt_expire: assert property (@(posedge CLOCK) disable iff (RESET)
    (s_q.st == ST_IDLE && !cause && !wd_edge && tick && s_q.wdt == WDT_T - WW'(1))
      |=> s_q.st == ST_HOLD && !RESET_N_OUT)                        // RULE_06
    else $error("watchdog expiry gave no reset");
  chk_hold_restart: assert property (@(posedge CLOCK) disable iff (RESET)
    (s_q.st == ST_HOLD && cause) |=> s_q.st == ST_HELD && s_q.hold == '0) // RULE_05
    else $error("hold not restarted");
  sequence hold_done_s;
    s_q.st == ST_HOLD && !cause && tick && s_q.hold == HOLD_T - HW'(1);
  endsequence
  chk_hold_release: assert property (@(posedge CLOCK) disable iff (RESET)
    hold_done_s |=> RESET_N_OUT)                                     // RULE_03
    else $error("hold end did not release");
  chk_release_only: assert property (@(posedge CLOCK) disable iff (RESET)
    $rose(RESET_N_OUT) |-> $past(s_q.st) == ST_HOLD && $past(s_q.hold) == HOLD_T - HW'(1)) // RULE_01
    else $error("release without full hold");
  chk_mr_filter: assert property (@(posedge CLOCK) disable iff (RESET)
    (mr_s ##1 !mr_s ##1 mr_s) |-> !mr_low)                          // RULE_16
    else $error("short manual pulse accepted");
endmodule : srw_top
`default_nettype wire
